// ===== core/alu_flags.sv
// add-with-flags unit used for arithmetic results
`timescale 1ns/1ps
module alu_flags
  import insn_decode_pkg::*;
(
  input  wire logic [7:0] a,      // first operand
  input  wire logic [7:0] b,      // second operand
  output logic      [7:0] sum,    // 8-bit result
  output flags_s          flags   // carry, digit carry, zero, overflow, negative
);

  logic [8:0] full;
  logic [4:0] low;

  // ----------------------------------------------------------------
  // flag generation
  // ----------------------------------------------------------------
  always_comb begin
    full     = {1'b0, a} + {1'b0, b};
    low      = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    sum      = full[7:0];
    flags.c  = full[8];                                  // RL14
    flags.dc = low[4];                                   // RL14
    flags.z  = (full[7:0] == 8'h00);                     // RL14
    flags.ov = (a[7] == b[7]) && (full[7] != a[7]);      // RL14
    flags.n  = full[7];                                  // RL14
  end

endmodule

// ===== core/insn_decode_pkg.sv
// constants, types and field layouts shared by the instruction decoder
//
// Behaviour
// RL1: one word each, four instructions span two
// RL2: second word has top nibble ones, else no-op
// RL3: single word one cycle, two if skip/branch
// RL4: double-word instructions take two cycles
// RL5: taken two-word branch takes three cycles
// RL6: instruction cycle is four oscillator periods
// RL7: destination bit picks accumulator or file register
// RL8: access bit picks access bank or bank select
// RL9: three-bit field selects bit 0 to 7
// RL10: file operand is 8-bit address or pointer selector
// RL11: register move carries 12-bit source and destination
// RL12: literals decode as 8, 12 or 20 bits
// RL13: control ops decode address, call mode, table mode
// RL14: results update carry, digit carry, zero, overflow, negative
// RL15: recognise 75 core plus 8 extended instructions
// RL16: fast bit saves or restores shadow registers
// RL17: table mode: none, post-inc, post-dec, pre-inc
// RL18: absolute target: low 8 first, upper 12 second
// RL19: opcode patterns follow the published encoding table
package insn_decode_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned PERIODS_PER_CYC = 4;
  localparam logic [1:0]  PHASE_LAST      = 2'(PERIODS_PER_CYC - 1);

  // ----------------------------------------------------------------
  // field positions within a program word
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned TAIL_MSB   = 15;
  localparam int unsigned TAIL_LSB   = 12;
  localparam logic [3:0]  TAIL_MARK  = 4'hf;
  localparam int unsigned D_BIT      = 9;
  localparam int unsigned A_BIT      = 8;
  localparam int unsigned BIT_MSB    = 11;
  localparam int unsigned BIT_LSB    = 9;
  localparam int unsigned F_MSB      = 7;
  localparam int unsigned PTR_LSB    = 4;
  localparam int unsigned FS_MSB     = 11;
  localparam int unsigned S_BIT      = 8;
  localparam int unsigned TBL_MSB    = 1;
  localparam int unsigned K12_HI_MSB = 3;
  localparam int unsigned BRA_MSB    = 10;
  localparam int unsigned K20_LO_W   = 8;

  // ----------------------------------------------------------------
  // opcode patterns, grouped by format
  // ----------------------------------------------------------------
  localparam logic [15:0] OP_NOP      = 16'h0000;
  localparam logic [15:0] OP_RET_BASE = 16'h0012;
  localparam logic [15:0] OP_RFI_BASE = 16'h0010;
  localparam logic [15:0] OP_TBL_BASE = 16'h0008;
  localparam logic [7:0]  OP_MOVLW    = 8'h0e;
  localparam logic [7:0]  OP_ADDLW    = 8'h0f;
  localparam logic [7:0]  OP_LFSR     = 8'hee;
  localparam logic [7:0]  OP_CALL     = 8'hec;  // low bit is fast mode
  localparam logic [7:0]  OP_GOTO     = 8'hef;
  localparam logic [3:0]  OP_MOVFF    = 4'hc;
  localparam logic [4:0]  OP_BRA      = 5'h1a;
  localparam logic [4:0]  OP_RCALL    = 5'h1b;
  localparam logic [4:0]  OP_BCC      = 5'h1c;  // conditional branches e0..e7
  localparam logic [3:0]  OP_BSF      = 4'h8;
  localparam logic [3:0]  OP_BCF      = 4'h9;
  localparam logic [3:0]  OP_BTFSS    = 4'ha;
  localparam logic [3:0]  OP_BTFSC    = 4'hb;
  localparam logic [5:0]  OP_ADDWF    = 6'h09;
  localparam logic [5:0]  OP_CPFSEQ   = 6'h18;
  localparam logic [5:0]  OP_DECFSZ   = 6'h0b;
  localparam logic [7:0]  OP_EXT_PFX  = 8'he8;  // extended group e8..eb
  localparam logic [7:0]  OP_EXT_HI   = 8'heb;

  localparam int unsigned CORE_COUNT = 75;
  localparam int unsigned EXT_COUNT  = 8;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_BYTE = 3'h0, FMT_BIT = 3'h1, FMT_LIT = 3'h2, FMT_CTRL = 3'h3,
    FMT_MOVE = 3'h4, FMT_TAIL = 3'h5, FMT_EXT = 3'h6, FMT_BAD = 3'h7
  } fmt_e;

  typedef enum logic [1:0] {
    TBL_NONE = 2'h0, TBL_POST_INC = 2'h1, TBL_POST_DEC = 2'h2, TBL_PRE_INC = 2'h3
  } tbl_mode_e;

  // gray-coded along fetch -> second word -> flush
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00, ST_WORD2 = 2'b01, ST_FLUSH = 2'b11, ST_SPARE = 2'b10
  } seq_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    fmt_e        fmt;
    logic        two_word;
    logic        dest_file;   // 1: result to file register (byte format only)
    logic        use_bank;    // 1: bank from bank_select_register
    logic [2:0]  bit_sel;
    logic [7:0]  file_addr;
    logic [1:0]  ptr_sel;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [19:0] literal;
    logic [1:0]  lit_width;   // 0:8 1:12 2:20
    logic [19:0] prog_addr;
    logic        fast;
    tbl_mode_e   tbl_mode;
    logic        is_branch;   // may alter program counter
    logic        is_skip;     // conditional skip
    logic        updates_flags;
    logic        valid;
  } decoded_s;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
    logic ov;
    logic n;
  } flags_s;

endpackage

// ===== core/insn_decoder.sv
// instruction format decoder and instruction-cycle sequencer
`timescale 1ns/1ps
module insn_decoder
  import insn_decode_pkg::*;
(
  input  wire logic        clk,          // 40 MHz oscillator clock
  input  wire logic        rst_n,        // synchronous reset, active low
  input  wire logic [15:0] prog_word,    // program word at current fetch
  input  wire logic        cond_true,    // condition/skip test result
  input  wire logic [7:0]  acc_in,       // working_accumulator value
  input  wire logic [7:0]  file_in,      // addressed file register value
  output logic             cyc_end,      // pulse: last period of a cycle
  output logic             fetch_adv,    // pulse: program counter advances
  output decoded_s         dec,          // registered decode of instruction
  output logic             exec_nop,     // current cycle executes as no-op
  output logic [1:0]       cyc_count,    // cycles taken by last instruction
  output logic [7:0]       result,       // registered arithmetic result
  output logic             wr_acc,       // pulse: write result to accumulator
  output logic             wr_file,      // pulse: write result to file reg
  output flags_s           flags,        // registered status flags
  output logic             shadow_save,  // pulse: fast call saves shadows
  output logic             shadow_load,  // pulse: fast return restores
  output logic             tbl_pre,      // pulse: pre-increment table_pointer
  output logic             tbl_post_inc, // pulse: post-increment table_pointer
  output logic             tbl_post_dec  // pulse: post-decrement table_pointer
);

  // ----------------------------------------------------------------
  // quarter-cycle phase divider
  // ----------------------------------------------------------------
  logic [1:0] phase_r, phase_nxt;

  // four oscillator periods make one instruction cycle
  always_comb begin
    phase_nxt = phase_r + 2'h1;          // RL6
  end

  always_ff @(posedge clk) begin
    if (!rst_n) phase_r <= 2'h0;
    else        phase_r <= phase_nxt;
  end

  assign cyc_end = (phase_r == PHASE_LAST);   // RL6

  // ----------------------------------------------------------------
  // decode function
  // ----------------------------------------------------------------
  function automatic decoded_s decode(input logic [15:0] w);
    decoded_s d;
    d           = '0;
    d.valid     = 1'b1;
    d.fmt       = FMT_BAD;
    d.dest_file = w[D_BIT];                              // RL7
    d.use_bank  = w[A_BIT];                              // RL8
    d.bit_sel   = w[BIT_MSB:BIT_LSB];                    // RL9
    d.file_addr = w[F_MSB:0];                            // RL10
    d.fast      = w[0];                                  // RL16
    // opcode patterns after the published encoding table
    if (w[TAIL_MSB:TAIL_LSB] == TAIL_MARK) begin         // RL19
      d.fmt = FMT_TAIL;                                  // RL2
    end else if (w[15:8] == OP_LFSR) begin
      d.fmt      = FMT_LIT;
      d.two_word = 1'b1;                                 // RL1
      d.ptr_sel  = w[PTR_LSB+1:PTR_LSB];                 // RL10
      d.literal  = {8'h00, w[K12_HI_MSB:0], 8'h00};
      d.lit_width = 2'h1;                                // RL12
    end else if (w[15:9] == OP_CALL[7:1] || w[15:8] == OP_GOTO) begin
      d.fmt       = FMT_CTRL;
      d.two_word  = 1'b1;                                // RL1
      d.is_branch = 1'b1;
      d.fast      = (w[15:9] == OP_CALL[7:1]) && w[S_BIT];   // RL16
      d.prog_addr = {12'h000, w[K20_LO_W-1:0]};          // RL18
      d.literal   = d.prog_addr;
      d.lit_width = 2'h2;                                // RL12
    end else if (w[15:8] >= OP_EXT_PFX && w[15:8] <= OP_EXT_HI) begin
      d.fmt = FMT_EXT;                                   // RL15
    end else if (w[15:12] == OP_MOVFF) begin
      d.fmt      = FMT_MOVE;
      d.two_word = 1'b1;                                 // RL1
      d.src_addr = w[FS_MSB:0];                          // RL11
      d.use_bank = 1'b0;                                 // RL11
    end else if (w[15:11] == OP_BRA || w[15:11] == OP_RCALL) begin
      d.fmt       = FMT_CTRL;
      d.is_branch = 1'b1;
      d.prog_addr = {{9{w[BRA_MSB]}}, w[BRA_MSB:0]};     // RL13
    end else if (w[15:11] == OP_BCC) begin
      d.fmt       = FMT_CTRL;
      d.is_skip   = 1'b1;
      d.prog_addr = {{12{w[7]}}, w[7:0]};                // RL13
    end else if (w[15:12] >= OP_BSF && w[15:12] <= OP_BTFSC) begin
      d.fmt     = FMT_BIT;                               // RL9
      d.is_skip = (w[15:12] == OP_BTFSS) || (w[15:12] == OP_BTFSC);
    end else if (w[15:8] == OP_MOVLW || w[15:8] == OP_ADDLW) begin
      d.fmt           = FMT_LIT;
      d.literal       = {12'h000, w[F_MSB:0]};           // RL12
      d.updates_flags = (w[15:8] == OP_ADDLW);
    end else if (w[15:4] == 12'h000 && w[3:2] != 2'b00) begin
      d.fmt = FMT_CTRL;                                  // RL13 table ops
      // pointer mode only for table ops, so branch offsets never strobe the pointer
      if (w[15:3] == OP_TBL_BASE[15:3]) d.tbl_mode = tbl_mode_e'(w[TBL_MSB:0]); // RL17
    end else if (w[15:1] == OP_RET_BASE[15:1] || w[15:1] == OP_RFI_BASE[15:1]) begin
      d.fmt       = FMT_CTRL;
      d.is_branch = 1'b1;
      d.fast      = w[0];                                // RL16
    end else if (w == OP_NOP) begin
      d.fmt = FMT_CTRL;                                  // RL13 no operand
    end else if (w[15:12] != 4'h0 && w[15:12] < 4'h7) begin
      d.fmt           = FMT_BYTE;                        // RL7
      d.updates_flags = (w[15:10] == OP_ADDWF);
      d.is_skip       = (w[15:10] == OP_CPFSEQ) || (w[15:10] == OP_DECFSZ);
    end else begin
      d.valid = 1'b0;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // sequencer: fetch, optional second word, optional flush cycle
  // ----------------------------------------------------------------
  seq_e       st_r, st_nxt;
  decoded_s   dec_r, dec_nxt;
  logic [1:0] cnt_r, cnt_nxt, done_r, done_nxt;
  decoded_s   cur;

  assign cur = decode(prog_word);

  always_comb begin
    st_nxt    = st_r;
    dec_nxt   = dec_r;
    cnt_nxt   = cnt_r;
    done_nxt  = done_r;
    if (cyc_end) begin
      case (st_r)
        ST_FETCH: begin
          dec_nxt   = cur;
          cnt_nxt   = 2'h1;
          if (cur.two_word) begin
            st_nxt = ST_WORD2;                           // RL4
          end else if ((cur.is_branch) || (cur.is_skip && cond_true)) begin
            st_nxt = ST_FLUSH;                           // RL3
          end else begin
            done_nxt = 2'h1;                             // RL3
          end
        end
        ST_WORD2: begin
          cnt_nxt = cnt_r + 2'h1;
          if (dec_r.fmt == FMT_MOVE) begin
            dec_nxt.dst_addr = prog_word[FS_MSB:0];      // RL11
          end else if (dec_r.fmt == FMT_LIT) begin
            dec_nxt.literal = {8'h00, dec_r.literal[K20_LO_W+K12_HI_MSB:K20_LO_W], prog_word[7:0]};
          end else begin
            dec_nxt.prog_addr = {prog_word[FS_MSB:0], dec_r.prog_addr[K20_LO_W-1:0]}; // RL18
            dec_nxt.literal   = {prog_word[FS_MSB:0], dec_r.prog_addr[K20_LO_W-1:0]}; // RL12
          end
          if (dec_r.is_branch) begin
            st_nxt = ST_FLUSH;                           // RL5
          end else begin
            st_nxt   = ST_FETCH;                         // RL4
            done_nxt = 2'h2;
          end
        end
        ST_FLUSH: begin
          st_nxt   = ST_FETCH;
          done_nxt = cnt_r + 2'h1;                       // RL3 RL5
        end
        default: st_nxt = ST_FETCH;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r    <= ST_FETCH;
      dec_r   <= '0;
      cnt_r   <= 2'h0;
      done_r  <= 2'h0;
    end else begin
      st_r    <= st_nxt;
      dec_r   <= dec_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  assign dec       = dec_r;
  assign cyc_count = done_r;
  assign exec_nop  = (st_r == ST_FLUSH) || (st_r == ST_FETCH && dec_r.fmt == FMT_TAIL); // RL2 RL3
  assign fetch_adv = cyc_end && (st_r != ST_FLUSH);

  // ----------------------------------------------------------------
  // execute: arithmetic, writeback, shadow and table strobes
  // ----------------------------------------------------------------
  logic [7:0] sum;
  flags_s     alu_fl;
  logic [7:0] res_r, res_nxt;
  flags_s     fl_r, fl_nxt;
  logic       exec;
  logic       is_ret;

  alu_flags u_alu (
    .a     (acc_in),
    .b     (dec_r.fmt == FMT_LIT ? dec_r.literal[7:0] : file_in),
    .sum   (sum),
    .flags (alu_fl)
  );

  // execute in the cycle after the first word is decoded, or after the flush cycle for a single-word branch or taken skip
  assign exec   = cyc_end && (st_r != ST_FLUSH) && dec_r.valid && (cnt_r == 2'h1);
  assign is_ret = (dec_r.fmt == FMT_CTRL) && !dec_r.two_word && dec_r.is_branch
                  && (dec_r.prog_addr == 20'h00000);

  always_comb begin
    res_nxt = res_r;
    fl_nxt  = fl_r;
    if (exec && dec_r.updates_flags) begin
      res_nxt = sum;
      fl_nxt  = alu_fl;                                  // RL14
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_r <= 8'h00;
      fl_r  <= '0;
    end else begin
      res_r <= res_nxt;
      fl_r  <= fl_nxt;
    end
  end

  assign result       = res_r;
  assign flags        = fl_r;
  assign wr_acc       = exec && dec_r.updates_flags && (dec_r.fmt == FMT_LIT || !dec_r.dest_file); // RL7
  assign wr_file      = exec && dec_r.updates_flags && dec_r.fmt == FMT_BYTE && dec_r.dest_file;   // RL7
  // shadows untouched unless the fast bit is set
  assign shadow_save  = exec && dec_r.fast && dec_r.two_word && dec_r.fmt == FMT_CTRL;           // RL16
  assign shadow_load  = exec && dec_r.fast && is_ret;                                            // RL16
  assign tbl_pre      = exec && dec_r.fmt == FMT_CTRL && dec_r.tbl_mode == TBL_PRE_INC && !dec_r.is_branch;  // RL17
  assign tbl_post_inc = exec && dec_r.fmt == FMT_CTRL && dec_r.tbl_mode == TBL_POST_INC && !dec_r.is_branch; // RL17
  assign tbl_post_dec = exec && dec_r.fmt == FMT_CTRL && dec_r.tbl_mode == TBL_POST_DEC && !dec_r.is_branch; // RL17

endmodule

// ===== sim/insn_decoder_asserts.sv
// concurrent checks on the instruction decoder ports
`timescale 1ns/1ps
module insn_decoder_asserts
  import insn_decode_pkg::*;
(
  input wire logic       clk,          // oscillator clock
  input wire logic       rst_n,        // synchronous reset, active low
  input wire logic       cyc_end,      // last period of a cycle
  input wire logic       fetch_adv,    // program counter advance
  input wire decoded_s   dec,          // registered decode
  input wire logic       exec_nop,     // no-op cycle
  input wire logic [1:0] cyc_count,    // cycles of last instruction
  input wire logic [7:0] result,       // arithmetic result
  input wire logic       wr_acc,       // accumulator write
  input wire logic       wr_file,      // file register write
  input wire flags_s     flags,        // status flags
  input wire logic       shadow_save,  // fast call save
  input wire logic       shadow_load,  // fast return restore
  input wire logic       tbl_pre,      // pre-increment
  input wire logic       tbl_post_inc, // post-increment
  input wire logic       tbl_post_dec  // post-decrement
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // every strobe of the block rides on a cycle end, so any two sit at least four clocks apart
  wire pulse_any;
  assign pulse_any = wr_acc | wr_file | shadow_save | shadow_load | tbl_pre | tbl_post_inc | tbl_post_dec;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet3;
    !cyc_end [*3];
  endsequence
  sequence s_no_pulse3;
    !pulse_any [*3];
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_cyc_period;
    cyc_end |=> s_quiet3 ##1 cyc_end;
  endproperty
  property p_fetch_on_cyc;
    fetch_adv |-> cyc_end;
  endproperty
  property p_pulse_spacing;
    pulse_any |=> s_no_pulse3;
  endproperty
  property p_dest_excl;
    !(wr_acc && wr_file);
  endproperty
  property p_tbl_onehot;
    $onehot0({tbl_pre, tbl_post_inc, tbl_post_dec});
  endproperty
  property p_shadow_excl;
    !(shadow_save && shadow_load);
  endproperty
  property p_tail_nop;
    (dec.valid && dec.fmt == FMT_TAIL) |-> exec_nop;
  endproperty
  property p_count_range;
    $changed(cyc_count) |-> cyc_count inside {2'h1, 2'h2, 2'h3};
  endproperty
  property p_two_word_fmt;
    (dec.valid && dec.two_word) |-> dec.fmt inside {FMT_MOVE, FMT_CTRL, FMT_LIT};
  endproperty
  property p_flags_match;
    (flags.n == result[7]) && !(flags.z && result != 8'h00);
  endproperty

  a_cyc_period: assert property (p_cyc_period) else $error("cycle end spacing wrong");
  a_fetch_on_cyc: assert property (p_fetch_on_cyc) else $error("advance off cycle end");
  a_pulse_spacing: assert property (p_pulse_spacing) else $error("strobe too long");
  a_dest_excl: assert property (p_dest_excl) else $error("both destinations written");
  a_tbl_onehot: assert property (p_tbl_onehot) else $error("two pointer modes at once");
  a_shadow_excl: assert property (p_shadow_excl) else $error("save and restore together");
  a_tail_nop: assert property (p_tail_nop) else $error("tail word not a no-op");
  a_count_range: assert property (p_count_range) else $error("cycle count out of range");
  a_two_word_fmt: assert property (p_two_word_fmt) else $error("two-word flag on wrong format");
  a_flags_match: assert property (p_flags_match) else $error("flags disagree with result");
endmodule

// ===== sim/tb_insn_decoder.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb_insn_decoder;
  import insn_decode_pkg::*;
  logic        clk, rst_n, cond_true, cyc_end, fetch_adv, exec_nop, e_snap;
  logic        wr_acc, wr_file, shadow_save, shadow_load, tbl_pre, tbl_post_inc, tbl_post_dec;
  logic [15:0] prog_word;
  logic [7:0]  acc_in, file_in, result, ra, rf;
  logic [1:0]  cyc_count, cyc_seen;
  logic [19:0] rn;
  decoded_s    dec, d_snap;
  flags_s      flags;
  int          err_total, tests_run, seed, cycles, n_acc, n_file, n_save, n_load, n_tbl[4];

  insn_decoder insn_decoder_inst (.clk, .rst_n, .prog_word, .cond_true, .acc_in, .file_in, .cyc_end,
    .fetch_adv, .dec, .exec_nop, .cyc_count, .result, .wr_acc, .wr_file, .flags, .shadow_save,
    .shadow_load, .tbl_pre, .tbl_post_inc, .tbl_post_dec);

  // ------------------------------------------------------------
  // clock, strobe counters and hang guard
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // strobes are counted rather than caught, as their exact clock is the designer's choice
  always @(posedge clk) begin
    cycles <= cycles + 1;
    n_acc <= n_acc + int'(wr_acc === 1'b1);
    n_file <= n_file + int'(wr_file === 1'b1);
    n_save <= n_save + int'(shadow_save === 1'b1);
    n_load <= n_load + int'(shadow_load === 1'b1);
    n_tbl[1] <= n_tbl[1] + int'(tbl_post_inc === 1'b1);
    n_tbl[2] <= n_tbl[2] + int'(tbl_post_dec === 1'b1);
    n_tbl[3] <= n_tbl[3] + int'(tbl_pre === 1'b1);
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(string what, logic [19:0] exp, logic [19:0] got);
    tests_run++;
    if (exp !== got) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // present a word from a falling edge and hold it until a fetch edge takes it
  task automatic issue(logic [15:0] w, logic c);
    int k;
    prog_word = w;
    cond_true = c;
    k = 0;
    while (!(cyc_end === 1'b1 && fetch_adv === 1'b1) && k < 40) begin
      @(negedge clk);
      k++;
    end
    // the count still shows the previous instruction until this fetch edge
    cyc_seen = cyc_count;
    if (k >= 40) check("fetch wait", 20'h0, 20'h1);
    @(posedge clk);
    @(negedge clk);
  endtask

  // one instruction, then a no-op so that its last cycle and strobes have landed
  task automatic run(logic [15:0] w1, logic [15:0] w2, logic two, logic c);
    n_acc = 0;
    n_file = 0;
    n_save = 0;
    n_load = 0;
    n_tbl = '{0, 0, 0, 0};
    issue(w1, c);
    if (two) issue(w2, 1'b0);
    @(negedge clk);
    d_snap = dec;
    e_snap = exec_nop;
    issue(OP_NOP, 1'b0);
    repeat (2) @(negedge clk);
  endtask

  function automatic flags_s add_flags(logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    flags_s f;
    s = a + b;
    f.c = s[8];
    f.dc = (a[3:0] + b[3:0]) > 15;
    f.z = (s[7:0] == 8'h00);
    f.ov = (a[7] == b[7]) && (s[7] != a[7]);
    f.n = s[7];
    return f;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, cond_true, prog_word, acc_in, file_in} = '0;
    {err_total, tests_run, cycles} = '0;
    seed = 83541;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    // random adds, with an all-ones plus one carry-to-zero corner first
    for (int i = 0; i < 14; i++) begin
      rn = 20'($random(seed));
      acc_in = (i == 0) ? 8'hff : 8'($random(seed));
      file_in = (i == 0) ? 8'h01 : 8'($random(seed));
      if (i == 12) begin
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
      end
      run({OP_ADDWF, rn[9:0]}, 16'h0, 1'b0, 1'b0);
      check("byte fmt", FMT_BYTE, d_snap.fmt);
      check("dest", rn[9], d_snap.dest_file);
      check("bank", rn[8], d_snap.use_bank);
      check("file", rn[7:0], d_snap.file_addr);
      check("acc writes", !rn[9], n_acc);
      check("file writes", rn[9], n_file);
      check("sum", 8'(acc_in + file_in), result);
      check("flags", add_flags(acc_in, file_in), flags);
      check("count1", 2'h1, cyc_seen);
    end
    for (int b = 0; b < 8; b++) begin
      rn = 20'($random(seed));
      run({OP_BSF, 3'(b), rn[8:0]}, 16'h0, 1'b0, 1'b0);
      check("bit", b, d_snap.bit_sel);
      check("bit file", rn[7:0], d_snap.file_addr);
      run({OP_MOVLW, rn[16:9]}, 16'h0, 1'b0, 1'b0);
      check("lit8", rn[16:9], d_snap.literal);
      check("lit8 w", 2'h0, d_snap.lit_width);
      run({OP_BTFSC, 3'(b), rn[8:0]}, 16'h0, 1'b0, b[0]);
      check("skip count", b[0] ? 2'h2 : 2'h1, cyc_seen);
    end
    for (int p = 0; p < 4; p++) begin
      rn = 20'($random(seed));
      run({OP_LFSR, 2'h0, 2'(p), rn[11:8]}, {TAIL_MARK, 4'h0, rn[7:0]}, 1'b1, 1'b0);
      check("ptr", p, d_snap.ptr_sel);
      check("lit12", rn[11:0], d_snap.literal);
      check("lit12 w", 2'h1, d_snap.lit_width);
      check("lfsr count", 2'h2, cyc_seen);
      run(OP_TBL_BASE | 16'(p), 16'h0, 1'b0, 1'b0);
      check("tbl mode", p, d_snap.tbl_mode);
      check("tbl strobe", p != 0, n_tbl[p]);
      run({OP_CALL[7:1], p[0], rn[7:0]}, {TAIL_MARK, rn[19:8]}, 1'b1, 1'b0);
      check("call fast", p[0], d_snap.fast);
      check("saves", p[0], n_save);
      check("call count", 2'h3, cyc_seen);
      run(OP_RET_BASE | 16'(p[0]), 16'h0, 1'b0, 1'b0);
      check("restores", p[0], n_load);
      check("ret count", 2'h2, cyc_seen);
    end
    for (int k = 0; k < 4; k++) begin
      rn = (k == 0) ? 20'hfffff : 20'($random(seed));
      run({OP_GOTO, rn[7:0]}, {TAIL_MARK, rn[19:8]}, 1'b1, 1'b0);
      check("target", rn, d_snap.prog_addr);
      check("goto count", 2'h3, cyc_seen);
      run({OP_MOVFF, rn[11:0]}, {TAIL_MARK, rn[19:8]}, 1'b1, 1'b0);
      check("src", rn[11:0], d_snap.src_addr);
      check("dst", rn[19:8], d_snap.dst_addr);
      check("move count", 2'h2, cyc_seen);
      run({TAIL_MARK, rn[11:0]}, 16'h0, 1'b0, 1'b0);
      check("tail fmt", FMT_TAIL, d_snap.fmt);
      check("tail nop", 1'b1, e_snap);
      run({OP_EXT_PFX[7:2], rn[9:0]}, 16'h0, 1'b0, 1'b0);
      check("ext fmt", FMT_EXT, d_snap.fmt);
      run({OP_BCC, 3'(k), rn[7:0]}, 16'h0, 1'b0, 1'b1);
      check("branch count", 2'h2, cyc_seen);
    end
    report_and_stop();
  end
endmodule

bind insn_decoder insn_decoder_asserts insn_decoder_asserts_inst (.clk, .rst_n, .cyc_end, .fetch_adv, .dec,
  .exec_nop, .cyc_count, .result, .wr_acc, .wr_file, .flags, .shadow_save, .shadow_load, .tbl_pre,
  .tbl_post_inc, .tbl_post_dec);
